/* File: bdec_pkg.sv */
package bdec_pkg;

    // opcode that enters background mode when enabled
    localparam logic [15:0] BDEC_ENTER_OPCODE   = 16'h4afa;
    // exception vectors reported to the exception path
    localparam logic [7:0]  BDEC_VEC_BREAKPOINT = 8'h0c;
    localparam logic [7:0]  BDEC_VEC_ILLEGAL    = 8'h04;
    // least low time of the request before reset release, in cycles
    localparam int          BDEC_STRAP_MIN_CYC  = 2;
    // synchroniser depth for pin inputs
    localparam int          BDEC_SYNC_STAGES    = 2;

    // entry sequencer states
    typedef enum logic [1:0] {
        BDEC_ST_RUN    = 2'b00,
        BDEC_ST_FREEZE = 2'b01,
        BDEC_ST_WAIT   = 2'b10,
        BDEC_ST_HALT   = 2'b11
    } bdec_state_type;

endpackage : bdec_pkg

/* File: bdec_sync.sv */
`timescale 1ns/1ps
module bdec_sync
    import bdec_pkg::*;
#(
    parameter int STAGES = BDEC_SYNC_STAGES
) (
    input  wire logic ref_clk_in,  // system clock
    input  wire logic async_in,    // pin level
    output logic      sync_out     // level after the last flop
);
    logic [STAGES-1:0] chain_q;

    // a metastable flop needs a second stage to settle
    if (STAGES < 2) begin : g_bad_stages
        $error("bdec_sync needs at least two stages");
    end

    // no reset on purpose: the chain keeps following the pin while
    // reset is held, so the strap level is settled at release
    always_ff @(posedge ref_clk_in) begin
        chain_q <= {chain_q[STAGES-2:0], async_in};
    end

    assign sync_out = chain_q[STAGES-1];
endmodule : bdec_sync

/* File: bdec_strap.sv */
`timescale 1ns/1ps
module bdec_strap
    import bdec_pkg::*;
(
    input  wire logic ref_clk_in,    // system clock
    input  wire logic sys_rst_in,    // async reset, active high
    input  wire logic strap_low_in,  // synchronised request is low
    output logic      enable_out     // debug mode enabled
);
    logic taken_q;
    logic enable_q;

    // catch the strap on the first clock after release; a constant
    // under reset, so each reset renews the decision
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            taken_q  <= 1'b0;
            enable_q <= 1'b0;
        end else if (!taken_q) begin
            taken_q  <= 1'b1;
            enable_q <= strap_low_in;
        end
    end

    assign enable_out = enable_q;
endmodule : bdec_strap

/* File: bdec_entry.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - request low at reset release enables debug mode until next reset.
// - request high at reset release leaves debug mode disabled.
// - the request is sampled afresh at every reset release.
// - enabled mode entered by request, opcode, double fault, peripheral.
// - software breakpoint instruction never enters debug mode.
// - disabled: acknowledged request gives breakpoint exception vector 0c.
// - request sampled at read-data time; no acknowledge cycle on entry.
// - opcode 4afa enters debug mode if enabled, else illegal trap.
// - double bus fault halts if disabled, enters debug mode if enabled.
// - on entry suspend execution, freeze first, then enable serial link.
// - disabled mode passes exceptions to the normal exception path.
module bdec_entry
    import bdec_pkg::*;
(
    input  wire logic        ref_clk_in,             // 100 MHz system clock
    input  wire logic        sys_rst_in,             // async reset, high
    input  wire logic        breakpoint_request_n_in, // tool pin, low
    input  wire logic        data_strobe_end_in,     // read data latch point
    input  wire logic        opcode_valid_in,        // decoder has opcode
    input  wire logic [15:0] opcode_in,              // decoded opcode
    input  wire logic        sw_breakpoint_in,       // breakpoint instruction
    input  wire logic        bus_fault_in,           // bus fault pulse
    input  wire logic        cycle_ok_in,            // clean bus cycle pulse
    input  wire logic        periph_break_in,        // peripheral breakpoint
    input  wire logic        resume_in,              // debug go command
    output logic             background_debug_mode_out, // mode enabled
    output logic             suspend_out,            // execution held
    output logic             freeze_out,             // in debug mode
    output logic             serial_enable_out,      // serial debug on
    output logic             halted_out,             // halted on fault
    output logic             exc_valid_out,          // exception request
    output logic [7:0]       exc_vector_out,         // exception vector
    output logic             sw_breakpoint_request_n_out,            // substitution cycle
    output logic             breakpoint_request_n_ack_cycle_out      // acknowledge cycle
);
    bdec_state_type state_q, state_d;
    logic           req_low;
    logic           enabled;
    logic           req_q;
    logic           fault_q;
    logic           exc_valid_q;
    logic [7:0]     exc_vector_q;
    logic           sw_breakpoint_request_n_q;
    logic           breakpoint_request_n_ack_q;
    logic [3:0]     stay_q;

    // two flops on the pin before anything reads it; the chain has no
    // reset, so it still follows the pin while reset is held
    bdec_sync #(.STAGES(BDEC_SYNC_STAGES)) u_sync (
        .ref_clk_in (ref_clk_in),
        .async_in   (breakpoint_request_n_in),
        .sync_out   (req_low)
    );

    // strap capture; the tool must keep the pin low long enough
    // for it to cross the synchroniser before release
    bdec_strap u_strap (
        .ref_clk_in   (ref_clk_in),
        .sys_rst_in   (sys_rst_in),
        .strap_low_in (!req_low),
        .enable_out   (enabled)
    );

    // event decode
    wire running    = (state_q == BDEC_ST_RUN);
    wire req_taken  = running && data_strobe_end_in && !req_low;
    wire opc_enter  = running && opcode_valid_in &&
                      (opcode_in == BDEC_ENTER_OPCODE);
    wire dbl_fault  = running && bus_fault_in && fault_q;
    wire per_break  = running && periph_break_in;
    wire sw_breakpoint_request_n    = running && opcode_valid_in && sw_breakpoint_in;
    wire enter_dbg  = enabled &&
                      (req_taken || opc_enter || dbl_fault || per_break);
    wire go_halt    = !enabled && dbl_fault;
    wire exc_breakpoint_request_n   = !enabled && req_taken;
    wire exc_ill    = !enabled && opc_enter;

    // track successive faults; a clean cycle breaks the chain
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fault_q <= 1'b0;
        end else if (bus_fault_in) begin
            fault_q <= 1'b1;
        end else if (cycle_ok_in) begin
            fault_q <= 1'b0;
        end
    end

    // entry sequence: freeze first, serial link one cycle later
    always_comb begin
        state_d = state_q;
        case (state_q)
            BDEC_ST_RUN: begin
                if (enter_dbg) begin
                    state_d = BDEC_ST_FREEZE;
                end else if (go_halt) begin
                    state_d = BDEC_ST_HALT;
                end
            end
            BDEC_ST_FREEZE: begin
                state_d = BDEC_ST_WAIT;
            end
            BDEC_ST_WAIT: begin
                if (resume_in) begin
                    state_d = BDEC_ST_RUN;
                end
            end
            BDEC_ST_HALT: begin
                state_d = BDEC_ST_HALT; // only reset leaves halt
            end
            default: begin
                state_d = BDEC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= BDEC_ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // exception path for the disabled case; breakpoint beats illegal
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            exc_valid_q  <= 1'b0;
            exc_vector_q <= 8'h00;
        end else begin
            exc_valid_q  <= exc_breakpoint_request_n || exc_ill;
            exc_vector_q <= exc_breakpoint_request_n ? BDEC_VEC_BREAKPOINT :
                            (exc_ill ? BDEC_VEC_ILLEGAL : 8'h00);
        end
    end

    // software breakpoint takes the substitution path whenever running;
    // acknowledge cycle only for a request outside debug entry
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sw_breakpoint_request_n_q  <= 1'b0;
            breakpoint_request_n_ack_q <= 1'b0;
            req_q      <= 1'b0;
        end else begin
            sw_breakpoint_request_n_q  <= sw_breakpoint_request_n;
            breakpoint_request_n_ack_q <= exc_breakpoint_request_n;
            req_q      <= req_taken;
        end
    end

    // cycles spent frozen, saturating; lets a check span the whole
    // stay without a long repetition
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            stay_q <= 4'h0;
        end else if (!freeze_out) begin
            stay_q <= 4'h0;
        end else if (stay_q != 4'hf) begin
            stay_q <= stay_q + 4'h1;
        end
    end

    // outputs decoded from state flops
    assign background_debug_mode_out = enabled;
    assign suspend_out       = !running;
    assign freeze_out        = (state_q == BDEC_ST_FREEZE) ||
                               (state_q == BDEC_ST_WAIT);
    assign serial_enable_out = (state_q == BDEC_ST_WAIT);
    assign halted_out        = (state_q == BDEC_ST_HALT);
    assign exc_valid_out     = exc_valid_q;
    assign exc_vector_out    = exc_vector_q;
    assign sw_breakpoint_request_n_out       = sw_breakpoint_request_n_q;
    assign breakpoint_request_n_ack_cycle_out = breakpoint_request_n_ack_q;

    // assertions
    sequence seq_enter;
        running && enter_dbg;
    endsequence
    sequence seq_freeze_then_link;
        freeze_out && !serial_enable_out ##1 freeze_out && serial_enable_out;
    endsequence
    sequence seq_back_to_run;
        !freeze_out && !suspend_out && !serial_enable_out;
    endsequence

    AST_ENTRY_ORDER: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in) seq_enter |=> seq_freeze_then_link)
        else $error("freeze not ahead of serial enable");
    AST_SOURCES: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (running && enabled && (per_break || dbl_fault)) |=> freeze_out)
        else $error("enabled source did not enter debug mode");
    AST_FREEZE_HOLD: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (serial_enable_out && !resume_in) |=> freeze_out && serial_enable_out)
        else $error("freeze dropped while in debug mode");
    AST_VEC_BREAKPOINT_REQUEST_N: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        exc_breakpoint_request_n |=> exc_valid_out && !freeze_out &&
                     exc_vector_out == BDEC_VEC_BREAKPOINT)
        else $error("disabled request gave no vector 0c exception");
    AST_ILLEGAL: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (running && !enabled && opcode_valid_in &&
         opcode_in == BDEC_ENTER_OPCODE && !req_taken) |=>
        exc_valid_out && exc_vector_out == BDEC_VEC_ILLEGAL)
        else $error("opcode did not trap when disabled");
    AST_HALT: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        go_halt |=> halted_out && !freeze_out ##1 halted_out)
        else $error("double fault did not halt");
    AST_NO_ACK: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        enter_dbg |=> !breakpoint_request_n_ack_cycle_out)
        else $error("acknowledge cycle on debug entry");
    AST_SWBKPT: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (sw_breakpoint_request_n && !enter_dbg) |=> sw_breakpoint_request_n_out && !freeze_out)
        else $error("software breakpoint entered debug mode");
    AST_ENABLE_STICKY: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        $past(enabled) && $past(u_strap.taken_q) |-> enabled)
        else $error("debug enable changed without reset");
    AST_DISABLED_EXC: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (!enabled && running && req_taken && !dbl_fault) |=> !suspend_out)
        else $error("disabled exception suspended execution");

    // request outcome, judged with the enable seen when it was taken
    AST_REQ_ENTRY: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (req_q && $past(enabled)) |->
        freeze_out && !breakpoint_request_n_ack_cycle_out)
        else $error("enabled request did not enter quietly");
    AST_REQ_EXC: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (req_q && !$past(enabled)) |->
        breakpoint_request_n_ack_cycle_out && exc_vector_out == BDEC_VEC_BREAKPOINT)
        else $error("disabled request gave no breakpoint exception");
    AST_NO_EXC_ENABLED: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        $past(enabled) |->
        !exc_valid_out)
        else $error("exception raised while debug mode enabled");
    AST_DISABLED_NO_FREEZE: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (!enabled && running) |=>
        !freeze_out)
        else $error("debug entry while debug mode disabled");
    AST_SINGLE_FAULT: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (running && bus_fault_in && !fault_q && !enter_dbg) |=>
        !halted_out && !freeze_out)
        else $error("single bus fault acted as double fault");
    AST_HALT_STICKY: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        halted_out |=>
        halted_out && !freeze_out)
        else $error("halt left without reset");
    AST_IGNORE_FROZEN: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (serial_enable_out && !resume_in) |=>
        !exc_valid_out && !sw_breakpoint_request_n_out)
        else $error("event acted on while waiting for a command");
    AST_RESUME: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (serial_enable_out && resume_in) |=>
        seq_back_to_run)
        else $error("resume did not return to normal execution");
    AST_STAY_LINK: assert property (@(posedge ref_clk_in)
        disable iff (sys_rst_in)
        (freeze_out && stay_q != 4'h0) |->
        serial_enable_out && suspend_out)
        else $error("serial link off during debug stay");
endmodule : bdec_entry

/* File: bdec_tool.sv */
`timescale 1ns/1ps
// tool model; the pin has a pull-up, so a released pin reads high
module bdec_tool (
    input  wire logic       ref_clk_in,               // system clock
    input  wire logic       sys_rst_in,               // system reset
    input  wire logic       strap_in,                 // want debug enabled
    input  wire logic       req_in,                   // want a break
    input  wire logic [3:0] lag_in,                   // slow answer cycles
    output logic            breakpoint_request_n_out  // tool pin
);
    logic [3:0] cnt_q;
    initial breakpoint_request_n_out = 1'b1;
    // strap held low all through reset, dropped on the first edge after
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            breakpoint_request_n_out <= ~strap_in;
            cnt_q <= lag_in;
        end else if (!req_in) begin
            breakpoint_request_n_out <= 1'b1;
            cnt_q <= lag_in;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            breakpoint_request_n_out <= 1'b0;
        end
    end
endmodule : bdec_tool

/* File: tb_bdec_entry.sv */
`timescale 1ns/1ps
module tb_bdec_entry;
    import bdec_pkg::*;
    logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, strap = 1'b0, req = 1'b0;
    logic [6:0]  pv = 7'h00;
    logic [15:0] op = 16'h0000;
    logic [3:0]  lag = 4'h0;
    logic [31:0] rng = 32'h0000_0038;
    logic        pin_n, mode, susp, frz, ser, halt, exv, swo, ack;
    logic [7:0]  vec;
    logic [7:0]  exp_q[$];
    int          error_cnt = 0, n_compared = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    bdec_tool i_bdec_tool (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .strap_in(strap), .req_in(req), .lag_in(lag),
        .breakpoint_request_n_out(pin_n));
    bdec_entry i_bdec_entry (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .breakpoint_request_n_in(pin_n),
        .data_strobe_end_in(pv[2]), .opcode_valid_in(pv[1]),
        .opcode_in(op), .sw_breakpoint_in(pv[4]), .bus_fault_in(pv[3]),
        .cycle_ok_in(pv[6]), .periph_break_in(pv[0]), .resume_in(pv[5]),
        .background_debug_mode_out(mode), .suspend_out(susp),
        .freeze_out(frz), .serial_enable_out(ser), .halted_out(halt),
        .exc_valid_out(exv), .exc_vector_out(vec), .sw_breakpoint_request_n_out(swo),
        .breakpoint_request_n_ack_cycle_out(ack));
    // fixed-seed xorshift; 4afa is steered away so plain opcodes stay inert
    function automatic logic [15:0] rop();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return (rng[15:0] == BDEC_ENTER_OPCODE) ? 16'h0000 : rng[15:0];
    endfunction : rop
    task automatic end_of_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit
    task automatic cmp_code(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error result expected %h seen %h", e, g);
        end
    endtask : cmp_code
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : step
    // one-cycle event pulse; returns two edges later, outputs settled
    task automatic ev(input logic [6:0] m, input logic [15:0] o);
        pv = m;
        op = o;
        step(1);
        pv = 7'h00;
        step(1);
    endtask : ev
    // every noted result must have shown up by now
    task automatic drain;
        step(3);
        cmp_code(8'h00, 8'(exp_q.size()));
        exp_q.delete();
    endtask : drain
    task automatic do_reset(input logic s, input logic e);
        sys_rst_in = 1'b1;
        strap = s;
        step(8);
        sys_rst_in = 1'b0;
        step(2);
        cmp_bit("mode", e, mode);
    endtask : do_reset
    // tool asks slowly, pin goes through the sync, then a strobe samples it
    task automatic rq;
        int n;
        logic [15:0] r;
        r = rop();
        lag = r[3:0];
        req = 1'b1;
        for (n = 0; n < 40 && pin_n !== 1'b0; n++) step(1);
        cmp_bit("tool pin", 1'b0, pin_n);
        if (pin_n !== 1'b0) end_of_test;
        step(2);
        ev(7'h04, op);
        req = 1'b0;
    endtask : rq
    // watcher: codes f0 freeze, f1 halt, f2 sw breakpoint, f3 ack cycle
    task automatic chk(input logic [7:0] g);
        if (exp_q.size() == 0) cmp_code(8'hff, g);
        else cmp_code(exp_q.pop_front(), g);
    endtask : chk
    initial begin : watch
        logic pf, ph;
        pf = 1'b0;
        ph = 1'b0;
        forever begin
            @(posedge ref_clk_in);
            #2;
            if (frz === 1'b1 && !pf) begin
                chk(8'hf0);
                cmp_bit("serial early", 1'b0, ser);
                cmp_bit("suspend", 1'b1, susp);
            end
            if (halt === 1'b1 && !ph) chk(8'hf1);
            if (exv === 1'b1 && swo !== 1'b1) chk(vec);
            if (swo === 1'b1) chk(8'hf2);
            if (ack === 1'b1) chk(8'hf3);
            pf = (frz === 1'b1);
            ph = (halt === 1'b1);
        end
    end
    initial begin : guard
        #300000;
        error_cnt++;
        end_of_test;
    end
    initial begin : main
        int i, n;
        logic [15:0] r;
        do_reset(1'b0, 1'b0);
        exp_q.push_back(BDEC_VEC_BREAKPOINT);
        exp_q.push_back(8'hf3);
        rq();
        drain;
        exp_q.push_back(BDEC_VEC_ILLEGAL);
        ev(7'h02, BDEC_ENTER_OPCODE);
        drain;
        exp_q.push_back(8'hf2);
        ev(7'h12, rop());
        ev(7'h02, rop()); // plain opcode gives nothing
        ev(7'h04, op); // strobe with pin high gives nothing
        ev(7'h08, op); // cleared fault chain gives no halt
        ev(7'h40, op);
        ev(7'h08, op);
        drain;
        exp_q.push_back(8'hf1);
        ev(7'h08, op);
        ev(7'h02, BDEC_ENTER_OPCODE); // ignored once halted
        drain;
        do_reset(1'b1, 1'b1);
        // each enabled source in turn, then a stay of random length
        for (i = 0; i < 4; i++) begin
            exp_q.push_back(8'hf0);
            if (i == 0) ev(7'h01, op);
            else if (i == 1) ev(7'h02, BDEC_ENTER_OPCODE);
            else if (i == 2) rq();
            else begin
                ev(7'h08, op);
                ev(7'h08, op);
            end
            cmp_bit("serial", 1'b1, ser);
            ev(7'h01, op); // refused while frozen
            r = rop();
            n = int'(r[2:0]) + 1;
            repeat (n) begin
                step(1);
                cmp_bit("freeze", 1'b1, frz);
            end
            ev(7'h20, op);
            cmp_bit("freeze off", 1'b0, frz);
            drain;
        end
        exp_q.push_back(8'hf2);
        ev(7'h12, rop());
        drain;
        cmp_bit("mode kept", 1'b1, mode);
        do_reset(1'b0, 1'b0);
        end_of_test;
    end
endmodule : tb_bdec_entry
